// ### hw/acc_adc_ctrl.sv
// converter control: wishbone registers, trigger logic, prescaler and sar sequencer
`timescale 1ns/1ps
module acc_adc_ctrl (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] TRIGGER_IN,
  input wire logic COMPARATOR_IN,
  output logic [acc_pkg::RES_W-1:0] DAC_CODE,
  output logic SAMPLE_HOLD,
  output logic ANALOG_ENABLE,
  output acc_pkg::acc_mux_type MUX_SEL,
  output logic CONV_DONE
);
  import acc_pkg::*;

  logic [7:0] ctrl_a_r;
  logic [2:0] tsel_r;
  logic [7:0] insel_r;
  logic pwr_r;
  logic ate_r;
  logic en_r;
  logic start_r;
  logic flag_r;
  logic [RES_W-1:0] result_r;
  logic blocked_r;
  logic [7:0] trig_prev_r;
  logic [6:0] psc_cnt_r;
  logic first_r;
  logic [4:0] cyc_r;
  logic [4:0] total_r;
  logic [RES_W-1:0] sar_r;
  logic [3:0] bit_r;
  logic done_r;
  acc_state_type state_r;
  acc_mux_type mux_nxt;
  acc_mux_type mux_r;
  logic [7:0] psc_limit;
  logic adc_tick;
  logic trig_lvl;
  logic trig_prev;
  logic trig_edge;
  logic wr_stb;
  logic rd_stb;
  logic wr_a;
  logic sw_start;
  logic auto_start;
  logic busy;
  logic conv_last;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic [31:0] rd_data;
  logic usable;

  // --------------------------------------------------------------
  // wishbone slave: one wait state, ack dropped the cycle after
  // --------------------------------------------------------------
  assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
  assign rd_stb = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
  assign wr_a = wr_stb && (WB_ADR_I == CTRL_A_OFS);
  // power reduction overrides the enable bit
  assign usable = en_r && !pwr_r;

  // ack generation, one cycle after request
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
    end else if (CLK_EN) begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end
  end

  // result bytes per adjust setting
  always_comb begin
    if (insel_r[LADJ_BIT]) begin
      res_high = result_r[9:2];
      res_low = {result_r[1:0], 6'h00};
    end else begin
      res_high = {6'h00, result_r[9:8]};
      res_low = result_r[7:0];
    end
  end

  // read multiplexer; unmapped reads as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (WB_ADR_I)
      CTRL_A_OFS: rd_data = {24'h0, en_r, start_r, ate_r, flag_r, ctrl_a_r[3:0]};
      CTRL_B_OFS: rd_data = {29'h0, tsel_r};
      INSEL_OFS: rd_data = {24'h0, insel_r};
      RES_LOW_OFS: rd_data = {24'h0, res_low};
      RES_HIGH_OFS: rd_data = {24'h0, res_high};
      POWER_OFS: rd_data = {31'h0, pwr_r};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (CLK_EN && rd_stb) begin
      WB_DAT_O <= rd_data;
    end
  end

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_a_r <= CTRL_A_RST;
      tsel_r <= CTRL_B_RST[2:0];
      insel_r <= INSEL_RST;
      pwr_r <= PWR_RST;
      ate_r <= 1'b0;
      en_r <= 1'b0;
    end else if (CLK_EN && wr_stb) begin
      unique case (WB_ADR_I)
        CTRL_A_OFS: begin
          ctrl_a_r <= WB_DAT_I[7:0];
          en_r <= WB_DAT_I[EN_BIT];
          ate_r <= WB_DAT_I[ATE_BIT];
        end
        CTRL_B_OFS: tsel_r <= WB_DAT_I[TSEL_LSB +: TSEL_W];
        INSEL_OFS: insel_r <= WB_DAT_I[7:0];
        POWER_OFS: pwr_r <= WB_DAT_I[PWR_BIT];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------
  // trigger edge detection
  // --------------------------------------------------------------
  // source 0 is the own flag; others are peripheral flags set by their events
  assign trig_lvl = (tsel_r == TSEL_SELF) ? flag_r : TRIGGER_IN[tsel_r];
  assign trig_prev = trig_prev_r[tsel_r];
  assign trig_edge = trig_lvl && !trig_prev;
  assign busy = (state_r != ACC_IDLE);
  assign sw_start = wr_a && WB_DAT_I[START_BIT] && usable && !busy;
  // free running restarts on completion; external edges ignored while busy
  assign auto_start = ate_r && usable && !busy &&
                      ((tsel_r == TSEL_SELF) ? start_r : trig_edge);

  // previous sampled trigger levels
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      trig_prev_r <= 8'h00;
    end else if (CLK_EN) begin
      trig_prev_r <= {TRIGGER_IN[7:1], flag_r};
    end
  end

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  assign psc_limit = 8'h01 << ctrl_a_r[PSC_LSB +: PSC_W];
  assign adc_tick = ({1'b0, psc_cnt_r} == psc_limit - 8'h01);

  // reset while disabled and on a trigger start
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      psc_cnt_r <= 7'h00;
    end else if (CLK_EN) begin
      if (!usable || (auto_start && tsel_r != TSEL_SELF)) begin
        psc_cnt_r <= 7'h00;
      end else if (adc_tick) begin
        psc_cnt_r <= 7'h00;
      end else begin
        psc_cnt_r <= psc_cnt_r + 7'h01;
      end
    end
  end

  // --------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------
  assign conv_last = (state_r == ACC_CONV) && adc_tick && (cyc_r == total_r - 5'd1);

  // sequencer state, cycle count and sar register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= ACC_IDLE;
      cyc_r <= 5'd0;
      total_r <= NORMAL_CYC;
      sar_r <= '0;
      bit_r <= 4'd0;
      first_r <= 1'b1;
      done_r <= 1'b0;
    end else if (CLK_EN) begin
      done_r <= 1'b0;
      if (!usable) begin
        state_r <= ACC_IDLE;
        first_r <= 1'b1;
      end else begin
        unique case (state_r)
          ACC_IDLE: if (sw_start || auto_start) begin
            state_r <= ACC_WAIT;
          end
          ACC_WAIT: if (adc_tick) begin
            // conversion starts at the next converter clock edge
            state_r <= ACC_CONV;
            cyc_r <= 5'd0;
            total_r <= first_r ? FIRST_CYC : NORMAL_CYC;
            first_r <= 1'b0;
            sar_r <= 10'h200;
            bit_r <= 4'd9;
          end
          ACC_CONV: if (adc_tick) begin
            cyc_r <= cyc_r + 5'd1;
            // one decision per clock once sampling has passed
            if (cyc_r >= total_r - 5'd11 && cyc_r < total_r - 5'd1) begin
              sar_r[bit_r] <= COMPARATOR_IN;
              if (bit_r != 4'd0) begin
                sar_r[bit_r - 4'd1] <= 1'b1;
                bit_r <= bit_r - 4'd1;
              end
            end
            if (conv_last) begin
              state_r <= ACC_IDLE;
              done_r <= 1'b1;
            end
          end
          default: state_r <= ACC_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // start bit and completion flag
  // --------------------------------------------------------------
  // free running keeps start high so the next conversion follows at once
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      start_r <= 1'b0;
    end else if (CLK_EN) begin
      if (!usable) begin
        start_r <= 1'b0;
      end else if (sw_start || auto_start) begin
        start_r <= 1'b1;
      end else if (conv_last && !(ate_r && tsel_r == TSEL_SELF)) begin
        start_r <= 1'b0;
      end
    end
  end

  // flag set on completion wins over a write-one clear
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      flag_r <= 1'b0;
    end else if (CLK_EN) begin
      if (conv_last) begin
        flag_r <= 1'b1;
      end else if (wr_a && WB_DAT_I[FLAG_BIT]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // result register and read lock
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      blocked_r <= 1'b0;
    end else if (CLK_EN && rd_stb) begin
      if (WB_ADR_I == RES_HIGH_OFS) begin
        blocked_r <= 1'b0;
      end else if (WB_ADR_I == RES_LOW_OFS) begin
        blocked_r <= 1'b1;
      end
    end
  end

  // resolved code taken on completion unless blocked
  // bit 0 was already decided on the previous converter clock
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      result_r <= '0;
    end else if (CLK_EN && conv_last && !blocked_r) begin
      result_r <= sar_r;
    end
  end

  // --------------------------------------------------------------
  // analog front end selection
  // --------------------------------------------------------------
  always_comb begin
    mux_nxt.ref_sel = insel_r[REF_LSB +: 2];
    mux_nxt.chan = {1'b0, insel_r[CHAN_LSB +: CHAN_W]};
    // codes 8 and up are differential; single ended bypasses the amplifier
    mux_nxt.differential = insel_r[CHANHI_BIT] || insel_r[4];
    // first gain-capable codes: 8..b pair 0/1, 0c..0f pair 2/3 at gain 1,10,200
    unique case (insel_r[4:2])
      3'h2: mux_nxt.gain = 2'h1;
      3'h3: mux_nxt.gain = 2'h2;
      default: mux_nxt.gain = 2'h0;
    endcase
  end

  // while enabled follow writes when idle or waiting or in last cycle; hold during conversion and while disabled
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mux_r <= '0;
    end else if (CLK_EN && usable) begin
      if (state_r != ACC_CONV || (cyc_r == total_r - 5'd1)) begin
        mux_r <= mux_nxt;
      end
    end
  end

  // --------------------------------------------------------------
  // outputs, all registered
  // --------------------------------------------------------------
  // trial code straight from the sar flops so each decision sees its own trial
  assign DAC_CODE = sar_r;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      MUX_SEL <= '0;
      SAMPLE_HOLD <= 1'b0;
      ANALOG_ENABLE <= 1'b0;
      CONV_DONE <= 1'b0;
    end else if (CLK_EN) begin
      MUX_SEL <= mux_r;
      SAMPLE_HOLD <= (state_r == ACC_CONV) && (cyc_r < total_r - 5'd11);
      ANALOG_ENABLE <= usable;
      CONV_DONE <= done_r;
    end
  end
endmodule

// ### hw/acc_pkg.sv
// package: register map, fields, timing and carrier types for the converter control
package acc_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] CTRL_A_OFS = 8'h00;
  localparam logic [7:0] CTRL_B_OFS = 8'h04;
  localparam logic [7:0] INSEL_OFS = 8'h08;
  localparam logic [7:0] RES_LOW_OFS = 8'h0c;
  localparam logic [7:0] RES_HIGH_OFS = 8'h10;
  localparam logic [7:0] POWER_OFS = 8'h14;
  // control a fields
  localparam int EN_BIT = 7;
  localparam int START_BIT = 6;
  localparam int ATE_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int PSC_LSB = 0;
  localparam int PSC_W = 3;
  // control b fields
  localparam int TSEL_LSB = 0;
  localparam int TSEL_W = 3;
  // input select fields
  localparam int REF_LSB = 6;
  localparam int LADJ_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int CHANHI_BIT = 3;
  // power reduction field
  localparam int PWR_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] INSEL_RST = 8'h00;
  localparam logic PWR_RST = 1'b1;
  // timing in converter clock cycles
  localparam logic [4:0] NORMAL_CYC = 5'd13;
  localparam logic [4:0] FIRST_CYC = 5'd25;
  localparam int RES_W = 10;
  // trigger source codes
  localparam logic [2:0] TSEL_SELF = 3'h0;
  // selection carried to the analog front end
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [5:0] chan;
    logic differential;
    logic [1:0] gain;
  } acc_mux_type;
  // converter state
  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_CONV} acc_state_type;
endpackage

// ### testbench/acc_adc_ctrl_assertions.sv
// port checker for the converter control
`timescale 1ns/1ps
module acc_adc_ctrl_chk (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic SAMPLE_HOLD,
  input wire logic ANALOG_ENABLE,
  input wire acc_pkg::acc_mux_type MUX_SEL,
  input wire logic CONV_DONE
);
  import acc_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET || !CLK_EN);
  sequence req_taken_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_once_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  bus_ack_a: assert property (req_taken_s |=> ack_once_s)
    else $error("request not answered by a single ack");
  ack_idle_a: assert property (!WB_CYC_I |=> !WB_ACK_O)
    else $error("ack without a request");
  power_gate_a: assert property (!ANALOG_ENABLE && !$past(ANALOG_ENABLE) |-> !SAMPLE_HOLD)
    else $error("sampling while converter is off");
  sel_off_a: assert property (!ANALOG_ENABLE && !$past(ANALOG_ENABLE) |-> $stable(MUX_SEL))
    else $error("selection moved while converter is off");
  sel_lock_a: assert property (SAMPLE_HOLD && $past(SAMPLE_HOLD) |-> $stable(MUX_SEL))
    else $error("selection moved during sampling");
  done_pulse_a: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("completion pulse longer than one cycle");
  done_enabled_a: assert property (CONV_DONE |-> $past(ANALOG_ENABLE, 3))
    else $error("completion without an enabled converter");
  hold_gap_a: assert property ($fell(SAMPLE_HOLD) |-> !CONV_DONE [*8])
    else $error("completion too soon after sampling");
endmodule
bind acc_adc_ctrl acc_adc_ctrl_chk acc_adc_ctrl_chk_inst (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SAMPLE_HOLD(SAMPLE_HOLD),
  .ANALOG_ENABLE(ANALOG_ENABLE), .MUX_SEL(MUX_SEL), .CONV_DONE(CONV_DONE));

// ### testbench/acc_comp_model.sv
// comparator front end model for the converter control
`timescale 1ns/1ps
module acc_comp_model (
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic comparator_in
);
  // keep the trial bit while the held input is at or above the trial code
  assign comparator_in = (vin >= dac_code);
endmodule

// ### testbench/tb_acc_adc_ctrl.sv
// testbench for the converter control
`timescale 1ns/1ps
module tb_acc_adc_ctrl;
  import acc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, trig = 8'h00;
  logic [31:0] dat = 32'h0, dout, q;
  logic [9:0] vin = 10'h000, dac;
  logic ack, comp, sh, aen, done;
  acc_mux_type msel, m0;
  int fails = 0, tests_run = 0, ticks = 0, n;
  // ----------------------------------------
  // clock, design and front end
  // ----------------------------------------
  always #10 clk = ~clk;
  acc_adc_ctrl acc_adc_ctrl_inst (.CORE_CLK(clk), .RESET(rst), .CLK_EN(clk_en), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .TRIGGER_IN(trig), .COMPARATOR_IN(comp), .DAC_CODE(dac), .SAMPLE_HOLD(sh), .ANALOG_ENABLE(aen),
    .MUX_SEL(msel), .CONV_DONE(done));
  acc_comp_model acc_comp_model_inst (.dac_code(dac), .vin(vin), .comparator_in(comp));
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic res(input logic [9:0] v, input logic l);
    wb(1'b0, RES_LOW_OFS, 32'h0);
    chk(q[7:0], l ? {v[1:0], 6'h00} : v[7:0]);
    wb(1'b0, RES_HIGH_OFS, 32'h0);
    chk(q[7:0], l ? v[9:2] : {6'h00, v[9:8]});
  endtask
  task automatic conv(input int lo, input int hi);
    wb(1'b1, CTRL_A_OFS, 32'hd0);
    wb(1'b0, CTRL_A_OFS, 32'h0);
    chk(q[START_BIT], 1'b1);
    wait_done();
    chk(n >= lo && n <= hi, 1'b1);
    repeat (3) @(posedge clk);
  endtask
  task automatic s_regs();
    wb(1'b0, CTRL_A_OFS, 32'h0);
    chk(q[7:0], CTRL_A_RST);
    wb(1'b0, INSEL_OFS, 32'h0);
    chk(q[7:0], INSEL_RST);
    wb(1'b0, POWER_OFS, 32'h0);
    chk(q[PWR_BIT], PWR_RST);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, INSEL_OFS, 32'h45);
    wb(1'b1, CTRL_A_OFS, 32'hc0);
    repeat (40) @(posedge clk);
    chk(aen, 1'b0);
    chk(msel, 32'h0);
    wb(1'b1, CTRL_A_OFS, 32'h0);
    wb(1'b1, POWER_OFS, 32'h0);
  endtask
  task automatic s_single();
    wb(1'b1, CTRL_A_OFS, 32'h80);
    repeat (3) @(posedge clk);
    chk(aen, 1'b1);
    chk(msel.ref_sel, 2'h1);
    vin <= 10'h2a5;
    conv(22, 30);
    wb(1'b0, CTRL_A_OFS, 32'h0);
    chk(q[7:4], 4'h9);
    res(10'h2a5, 1'b0);
  endtask
  task automatic s_lock();
    wb(1'b1, INSEL_OFS, 32'h65);
    vin <= 10'h0f3;
    wb(1'b1, CTRL_A_OFS, 32'hd0);
    repeat (3) @(posedge clk);
    m0 = msel;
    wb(1'b1, INSEL_OFS, 32'h62);
    chk(msel, m0);
    wait_done();
    chk(n >= 8 && n <= 18, 1'b1);
    repeat (3) @(posedge clk);
    chk(msel !== m0, 1'b1);
    res(10'h0f3, 1'b1);
    wb(1'b0, RES_LOW_OFS, 32'h0);
    vin <= 10'h31c;
    conv(8, 18);
    wb(1'b0, CTRL_A_OFS, 32'h0);
    chk(q[FLAG_BIT], 1'b1);
    wb(1'b0, RES_LOW_OFS, 32'h0);
    chk(q[7:0], 8'hc0);
    wb(1'b0, RES_HIGH_OFS, 32'h0);
    chk(q[7:0], 8'h3c);
    conv(8, 18);
    res(10'h31c, 1'b1);
  endtask
  // clock enable low freezes a conversion in flight
  task automatic s_hold();
    vin <= 10'h155;
    wb(1'b1, CTRL_A_OFS, 32'hd0);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b1;
    wait_done();
    chk(n >= 14 && n <= 16, 1'b1);
    repeat (3) @(posedge clk);
    res(10'h155, 1'b1);
  endtask
  task automatic s_trig();
    wb(1'b1, CTRL_B_OFS, 32'h3);
    wb(1'b1, CTRL_A_OFS, 32'hb0);
    trig <= 8'h08;
    repeat (5) @(posedge clk);
    trig <= 8'h00;
    repeat (2) @(posedge clk);
    trig <= 8'h08;
    wait_done();
    chk(done, 1'b1);
    @(posedge clk);
    wait_done();
    chk(n, 300);
    wb(1'b1, CTRL_A_OFS, 32'he0);
    wait_done();
    chk(done, 1'b1);
    trig <= 8'h00;
  endtask
  task automatic s_free();
    wb(1'b1, CTRL_B_OFS, 32'h0);
    wb(1'b1, CTRL_A_OFS, 32'hf0);
    repeat (3) begin
      @(posedge clk);
      wait_done();
      chk(done, 1'b1);
    end
    wb(1'b1, CTRL_A_OFS, 32'h0);
    repeat (4) @(posedge clk);
    wait_done();
    chk(n, 300);
    wb(1'b1, CTRL_A_OFS, 32'h80);
    conv(22, 30);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_single();
    s_lock();
    s_hold();
    s_trig();
    s_free();
    stop_test();
  end
endmodule
